//--- uart_path_pkg.sv
package uart_path_pkg;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [31:0] DATA_PORT_ADDR = 32'h808e0000;
   localparam logic [31:0] RX_STATUS_ADDR = 32'h808e0004;
   localparam logic [31:0] REG_RESET = 32'h00000000;
   localparam int OE_BIT = 3;
   localparam int BE_BIT = 2;
   localparam int PE_BIT = 1;
   localparam int FE_BIT = 0;

   // ----------------------------------------
   // Serial timing
   // ----------------------------------------
   localparam logic [3:0] SAMPLE_MID = 4'h7;
   localparam logic [3:0] TICKS_LAST = 4'hf;
   localparam logic [3:0] MIN_DATA_BITS = 4'h5;
   localparam logic [15:0] DIV_RESET = 16'h0000;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic brk;
      logic par;
      logic frm;
      logic [7:0] data;
   } rx_entry_t;

   typedef struct packed {
      logic fifo_mode_select;
      logic parity_check_select;
      logic even_parity;
      logic two_stop;
      logic [1:0] word_len;
      logic [15:0] baud_div;
   } line_ctrl_t;

   typedef struct packed {
      logic drive_enable_on_pin;
      logic hdlc_clock_direction;
      logic hdlc_clock_enable_third;
      logic hdlc_clock_enable_first;
   } pin_cfg_t;

   typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRK}
      rx_state_t;
   typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;

endpackage

//--- uart_path_fifo.sv
`timescale 1ns/1ps
module uart_path_fifo
   import uart_path_pkg::*;
#(
   parameter int W = 8,
   parameter int DEPTH = 16
)
(
   input wire logic CLK,            // System clock
   input wire logic RST,            // Synchronous reset
   input wire logic one_deep,       // Holding-register mode
   input wire logic push,           // Write request
   input wire logic [W-1:0] din,    // Write data
   input wire logic pop,            // Remove head
   output logic [W-1:0] dout,       // Head entry
   output logic full,               // No room
   output logic empty               // Nothing held
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [AW:0] cnt_r, cnt_nxt;
   logic [AW-1:0] wr_idx, rd_idx;
   logic do_push, do_pop;

   // ----------------------------------------
   // Pointer update
   // ----------------------------------------
   always_comb
   begin
      // Holding mode always uses the lowest slot
      wr_idx = one_deep ? '0 : wp_r;
      rd_idx = one_deep ? '0 : rp_r;
      empty = (cnt_r == '0);
      full = one_deep ? (cnt_r != '0) : (cnt_r == (AW+1)'(DEPTH));
      do_push = push && !full;
      do_pop = pop && !empty;
      wp_nxt = (do_push && !one_deep) ? wp_r + 1'b1 : wp_r;
      rp_nxt = (do_pop && !one_deep) ? rp_r + 1'b1 : rp_r;
      cnt_nxt = cnt_r + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
      dout = mem[rd_idx];
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end
      else
      begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
      if (do_push)
         mem[wr_idx] <= din;
   end

endmodule

//--- uart_path_top.sv
`timescale 1ns/1ps
module uart_path_top
   import uart_path_pkg::*;
#(
   parameter int FIFO_DEPTH = 16
)
(
   input wire logic CLK,                     // Bus clock
   input wire logic RST,                     // Synchronous reset
   input wire logic [31:0] ADDR,             // Register byte address
   input wire logic WR,                      // Register write strobe
   input wire logic RD,                      // Register read strobe
   input wire logic [31:0] WDATA,            // Write data
   output logic [31:0] RDATA,                // Read data, next cycle
   input wire line_ctrl_t LINE_CTRL,         // Line control settings
   input wire pin_cfg_t PIN_CFG,             // Shared pin configuration
   input wire logic INT_HDLC_CLK,            // Internal HDLC clock
   input wire logic TX_DMA_EN,               // Transmit DMA enable
   input wire logic RX_DMA_EN,               // Receive DMA enable
   input wire logic DMA_TX_VALID,            // DMA byte offered
   input wire logic [7:0] DMA_TX_DATA,       // DMA transmit byte
   output logic DMA_TX_READY,                // DMA byte taken
   output logic DMA_RX_VALID,                // DMA receive byte ready
   output logic [7:0] DMA_RX_DATA,           // DMA receive byte
   input wire logic DMA_RX_READY,            // DMA takes byte
   input wire logic SERIAL_RECEIVE_PIN,      // Serial input
   output logic SERIAL_TRANSMIT_PIN,         // Serial output
   input wire logic SHARED_GENERAL_PIN_IN,   // Shared pin level
   output logic SHARED_GENERAL_PIN_OUT,      // Shared pin drive value
   output logic SHARED_GENERAL_PIN_OE_N,     // Low while driving pin
   output logic HDLC_CLOCK_TO_CORE,          // External HDLC clock
   output logic RS485_DRIVE_ENABLE_OUT_N     // Transceiver enable
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [1:0] rxd_sync_r, gpio_sync_r;
   logic rxd, gpio;
   logic [15:0] div_r, div_nxt;
   logic tick;
   logic [3:0] nbits;
   logic wr_data, wr_sts, rd_data, rd_sts;
   logic oe_r, oe_nxt;
   logic [2:0] flags_r, flags_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   rx_entry_t rx_din, rx_dout;
   logic rx_push, rx_pop, rx_full, rx_empty, overrun;
   logic [7:0] tx_din, tx_dout;
   logic tx_push, tx_pop, tx_full, tx_empty;
   rx_state_t rx_st_r, rx_st_nxt;
   logic [3:0] rx_tk_r, rx_tk_nxt;
   logic [2:0] rx_bit_r, rx_bit_nxt;
   logic [7:0] rx_sh_r, rx_sh_nxt;
   logic rx_par_r, rx_par_nxt, rx_pbad_r, rx_pbad_nxt;
   logic rx_zero_r, rx_zero_nxt;
   tx_state_t tx_st_r, tx_st_nxt;
   logic [3:0] tx_tk_r, tx_tk_nxt;
   logic [2:0] tx_bit_r, tx_bit_nxt;
   logic [7:0] tx_sh_r, tx_sh_nxt;
   logic tx_par_r, tx_par_nxt, tx_stop2_r, tx_stop2_nxt;
   logic txd_r, txd_nxt;
   logic hold_v_r, hold_v_nxt, tx_rdy_r, tx_rdy_nxt;
   logic [7:0] hold_r, hold_nxt;
   logic out_v_r, out_v_nxt;
   logic [7:0] out_d_r, out_d_nxt;
   logic dma_accept, hold_drain, dma_load;
   logic ten_n_r, ten_n_nxt, hdlc_r, hdlc_nxt;
   logic pin_out_r, pin_out_nxt, pin_oe_n_r, pin_oe_n_nxt;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         rxd_sync_r <= 2'h3;
         gpio_sync_r <= 2'h0;
      end
      else
      begin
         rxd_sync_r <= {rxd_sync_r[0], SERIAL_RECEIVE_PIN};
         gpio_sync_r <= {gpio_sync_r[0], SHARED_GENERAL_PIN_IN};
      end
   end
   assign rxd = rxd_sync_r[1];
   assign gpio = gpio_sync_r[1];

   // ----------------------------------------
   // FIFOs
   // ----------------------------------------
   uart_path_fifo #(.W(11), .DEPTH(FIFO_DEPTH)) rx_fifo (
      .CLK(CLK),
      .RST(RST),
      .one_deep(!LINE_CTRL.fifo_mode_select),
      .push(rx_push),
      .din(rx_din),
      .pop(rx_pop),
      .dout(rx_dout),
      .full(rx_full),
      .empty(rx_empty)
   );

   uart_path_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) tx_fifo (
      .CLK(CLK),
      .RST(RST),
      .one_deep(!LINE_CTRL.fifo_mode_select),
      .push(tx_push),
      .din(tx_din),
      .pop(tx_pop),
      .dout(tx_dout),
      .full(tx_full),
      .empty(tx_empty)
   );

   // ----------------------------------------
   // Register port, DMA path and baud divider
   // ----------------------------------------
   always_comb
   begin
      wr_data = WR && (ADDR == DATA_PORT_ADDR);
      wr_sts = WR && (ADDR == RX_STATUS_ADDR);
      rd_data = RD && (ADDR == DATA_PORT_ADDR);
      rd_sts = RD && (ADDR == RX_STATUS_ADDR);
      // 16x sample enable standing in for the reference clock
      tick = (LINE_CTRL.baud_div != DIV_RESET) &&
             (div_r == LINE_CTRL.baud_div);
      div_nxt = (tick || LINE_CTRL.baud_div == DIV_RESET) ? DIV_RESET :
                div_r + 16'h0001;
      nbits = MIN_DATA_BITS + {2'h0, LINE_CTRL.word_len};
      // Bus write wins the transmit FIFO; DMA byte waits in hold
      hold_drain = hold_v_r && !wr_data && !tx_full;
      dma_accept = DMA_TX_VALID && tx_rdy_r;
      hold_v_nxt = dma_accept || (hold_v_r && !hold_drain);
      hold_nxt = dma_accept ? DMA_TX_DATA : hold_r;
      tx_rdy_nxt = TX_DMA_EN && !hold_v_nxt;
      tx_push = wr_data || hold_drain;
      tx_din = wr_data ? WDATA[7:0] : hold_r;
      // Bus read wins the receive FIFO head over DMA
      dma_load = RX_DMA_EN && !rx_empty && !rd_data &&
                 (!out_v_r || DMA_RX_READY);
      out_v_nxt = dma_load || (out_v_r && !DMA_RX_READY);
      out_d_nxt = dma_load ? rx_dout.data : out_d_r;
      rx_pop = (rd_data && !rx_empty) || dma_load;
      oe_nxt = overrun || (oe_r && !wr_sts);
      flags_nxt = wr_sts ? 3'h0 : flags_r;
      if (rd_data && !rx_empty)
         flags_nxt = {rx_dout.brk, rx_dout.par, rx_dout.frm};
      rdata_nxt = rdata_r;
      if (rd_data)
         rdata_nxt = {24'h0, rx_empty ? 8'h00 : rx_dout.data};
      else if (rd_sts)
         rdata_nxt = {28'h0, oe_r, flags_r};
      else if (RD)
         rdata_nxt = REG_RESET;
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         div_r <= DIV_RESET;
         hold_v_r <= 1'b0;
         hold_r <= 8'h00;
         tx_rdy_r <= 1'b0;
         out_v_r <= 1'b0;
         out_d_r <= 8'h00;
         oe_r <= 1'b0;
         flags_r <= 3'h0;
         rdata_r <= REG_RESET;
      end
      else
      begin
         div_r <= div_nxt;
         hold_v_r <= hold_v_nxt;
         hold_r <= hold_nxt;
         tx_rdy_r <= tx_rdy_nxt;
         out_v_r <= out_v_nxt;
         out_d_r <= out_d_nxt;
         oe_r <= oe_nxt;
         flags_r <= flags_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // ----------------------------------------
   // Receiver
   // ----------------------------------------
   always_comb
   begin
      rx_st_nxt = rx_st_r;
      rx_tk_nxt = rx_tk_r;
      rx_bit_nxt = rx_bit_r;
      rx_sh_nxt = rx_sh_r;
      rx_par_nxt = rx_par_r;
      rx_pbad_nxt = rx_pbad_r;
      rx_zero_nxt = rx_zero_r;
      rx_push = 1'b0;
      overrun = 1'b0;
      rx_din = '0;
      if (tick)
      begin
         rx_tk_nxt = rx_tk_r + 4'h1;
         unique case (rx_st_r)
            RX_IDLE:
            begin
               rx_tk_nxt = 4'h0;
               if (!rxd)
                  rx_st_nxt = RX_START;
            end
            RX_START:
               if (rx_tk_r == SAMPLE_MID)
               begin
                  rx_tk_nxt = 4'h0;
                  rx_st_nxt = rxd ? RX_IDLE : RX_DATA;
                  rx_bit_nxt = 3'h0;
                  rx_sh_nxt = 8'h00;
                  rx_par_nxt = 1'b0;
                  rx_pbad_nxt = 1'b0;
                  rx_zero_nxt = 1'b1;
               end
            RX_DATA:
               if (rx_tk_r == TICKS_LAST)
               begin
                  rx_sh_nxt[rx_bit_r] = rxd;
                  rx_par_nxt = rx_par_r ^ rxd;
                  rx_zero_nxt = rx_zero_r && !rxd;
                  rx_bit_nxt = rx_bit_r + 3'h1;
                  if ({1'b0, rx_bit_r} == nbits - 4'h1)
                     rx_st_nxt = LINE_CTRL.parity_check_select ?
                                 RX_PAR : RX_STOP;
               end
            RX_PAR:
               if (rx_tk_r == TICKS_LAST)
               begin
                  rx_pbad_nxt = ((rx_par_r ^ rxd) ==
                                 LINE_CTRL.even_parity);
                  rx_zero_nxt = rx_zero_r && !rxd;
                  rx_st_nxt = RX_STOP;
               end
            RX_STOP:
               if (rx_tk_r == TICKS_LAST)
               begin
                  rx_din.brk = rx_zero_r && !rxd;
                  rx_din.par = rx_pbad_r;
                  rx_din.frm = !rxd;
                  rx_din.data = rx_zero_r ? 8'h00 : rx_sh_r;
                  overrun = rx_full;
                  rx_push = !rx_full;
                  rx_st_nxt = (rx_zero_r && !rxd) ? RX_BRK : RX_IDLE;
               end
            RX_BRK:
               if (rxd)
                  rx_st_nxt = RX_IDLE;
         endcase
      end
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         rx_st_r <= RX_IDLE;
         rx_tk_r <= 4'h0;
         rx_bit_r <= 3'h0;
         rx_sh_r <= 8'h00;
         rx_par_r <= 1'b0;
         rx_pbad_r <= 1'b0;
         rx_zero_r <= 1'b0;
      end
      else
      begin
         rx_st_r <= rx_st_nxt;
         rx_tk_r <= rx_tk_nxt;
         rx_bit_r <= rx_bit_nxt;
         rx_sh_r <= rx_sh_nxt;
         rx_par_r <= rx_par_nxt;
         rx_pbad_r <= rx_pbad_nxt;
         rx_zero_r <= rx_zero_nxt;
      end
   end

   // ----------------------------------------
   // Transmitter
   // ----------------------------------------
   always_comb
   begin
      tx_st_nxt = tx_st_r;
      tx_tk_nxt = tx_tk_r;
      tx_bit_nxt = tx_bit_r;
      tx_sh_nxt = tx_sh_r;
      tx_par_nxt = tx_par_r;
      tx_stop2_nxt = tx_stop2_r;
      txd_nxt = txd_r;
      tx_pop = 1'b0;
      if (tx_st_r == TX_IDLE)
      begin
         if (!tx_empty)
         begin
            tx_pop = 1'b1;
            tx_sh_nxt = tx_dout;
            txd_nxt = 1'b0;
            tx_tk_nxt = 4'h0;
            tx_st_nxt = TX_START;
         end
      end
      else if (tick)
      begin
         tx_tk_nxt = tx_tk_r + 4'h1;
         if (tx_tk_r == TICKS_LAST)
            unique case (tx_st_r)
               TX_START:
               begin
                  txd_nxt = tx_sh_r[0];
                  tx_par_nxt = tx_sh_r[0];
                  tx_bit_nxt = 3'h0;
                  tx_st_nxt = TX_DATA;
               end
               TX_DATA:
                  if ({1'b0, tx_bit_r} == nbits - 4'h1)
                  begin
                     tx_stop2_nxt = 1'b0;
                     if (LINE_CTRL.parity_check_select)
                     begin
                        txd_nxt = tx_par_r ^ !LINE_CTRL.even_parity;
                        tx_st_nxt = TX_PAR;
                     end
                     else
                     begin
                        txd_nxt = 1'b1;
                        tx_st_nxt = TX_STOP;
                     end
                  end
                  else
                  begin
                     tx_sh_nxt = {1'b0, tx_sh_r[7:1]};
                     txd_nxt = tx_sh_r[1];
                     tx_par_nxt = tx_par_r ^ tx_sh_r[1];
                     tx_bit_nxt = tx_bit_r + 3'h1;
                  end
               TX_PAR:
               begin
                  txd_nxt = 1'b1;
                  tx_st_nxt = TX_STOP;
               end
               TX_STOP:
                  if (LINE_CTRL.two_stop && !tx_stop2_r)
                     tx_stop2_nxt = 1'b1;
                  else
                     tx_st_nxt = TX_IDLE;
               TX_IDLE:
                  tx_st_nxt = TX_IDLE;
            endcase
      end
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         tx_st_r <= TX_IDLE;
         tx_tk_r <= 4'h0;
         tx_bit_r <= 3'h0;
         tx_sh_r <= 8'h00;
         tx_par_r <= 1'b0;
         tx_stop2_r <= 1'b0;
         txd_r <= 1'b1;
      end
      else
      begin
         tx_st_r <= tx_st_nxt;
         tx_tk_r <= tx_tk_nxt;
         tx_bit_r <= tx_bit_nxt;
         tx_sh_r <= tx_sh_nxt;
         tx_par_r <= tx_par_nxt;
         tx_stop2_r <= tx_stop2_nxt;
         txd_r <= txd_nxt;
      end
   end

   // ----------------------------------------
   // Shared pin selection
   // ----------------------------------------
   always_comb
   begin
      ten_n_nxt = (tx_st_nxt == TX_IDLE) && tx_empty && !tx_push;
      hdlc_nxt = 1'b0;
      pin_out_nxt = 1'b0;
      pin_oe_n_nxt = 1'b1;
      if (PIN_CFG.hdlc_clock_enable_third)
      begin
         if (!PIN_CFG.hdlc_clock_enable_first)
         begin
            if (!PIN_CFG.hdlc_clock_direction)
               hdlc_nxt = gpio;
            else
            begin
               pin_out_nxt = INT_HDLC_CLK;
               pin_oe_n_nxt = 1'b0;
            end
         end
      end
      else if (PIN_CFG.drive_enable_on_pin &&
               !PIN_CFG.hdlc_clock_direction &&
               !PIN_CFG.hdlc_clock_enable_first)
      begin
         pin_out_nxt = ten_n_nxt;
         pin_oe_n_nxt = 1'b0;
      end
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         ten_n_r <= 1'b1;
         hdlc_r <= 1'b0;
         pin_out_r <= 1'b0;
         pin_oe_n_r <= 1'b1;
      end
      else
      begin
         ten_n_r <= ten_n_nxt;
         hdlc_r <= hdlc_nxt;
         pin_out_r <= pin_out_nxt;
         pin_oe_n_r <= pin_oe_n_nxt;
      end
   end

   assign RDATA = rdata_r;
   assign DMA_TX_READY = tx_rdy_r;
   assign DMA_RX_VALID = out_v_r;
   assign DMA_RX_DATA = out_d_r;
   assign SERIAL_TRANSMIT_PIN = txd_r;
   assign SHARED_GENERAL_PIN_OUT = pin_out_r;
   assign SHARED_GENERAL_PIN_OE_N = pin_oe_n_r;
   assign HDLC_CLOCK_TO_CORE = hdlc_r;
   assign RS485_DRIVE_ENABLE_OUT_N = ten_n_r;

endmodule

//--- uart_path_checker.sv
`timescale 1ns/1ps
module uart_path_checker
   import uart_path_pkg::*;
(
   input wire logic CLK, // Clock
   input wire logic RST, // Reset
   input wire logic [31:0] ADDR, // Address
   input wire logic WR, // Write
   input wire logic RD, // Read
   input wire logic [31:0] RDATA, // Read data
   input wire pin_cfg_t PIN_CFG, // Pin setup
   input wire logic SERIAL_TRANSMIT_PIN, // Serial out
   input wire logic SHARED_GENERAL_PIN_OE_N, // Pin drive
   input wire logic HDLC_CLOCK_TO_CORE, // HDLC clock
   input wire logic RS485_DRIVE_ENABLE_OUT_N, // Drive enable
   input wire logic DMA_TX_VALID, // DMA offer
   input wire logic DMA_TX_READY // DMA take
);
   logic pin_in, pin_out;
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);
   // Pin taken as input, or driven by the block
   assign pin_in = (PIN_CFG & 4'h7) == 4'h2;
   assign pin_out = (PIN_CFG & 4'h7) == 4'h6 || PIN_CFG == 4'h8;
   chk_clock_held_low: assert property (
      !PIN_CFG.hdlc_clock_enable_third
      && !$past(PIN_CFG.hdlc_clock_enable_third) |-> !HDLC_CLOCK_TO_CORE)
      else $error("hdlc clock not low");
   chk_pin_released: assert property (
      pin_in && $past(pin_in) |-> SHARED_GENERAL_PIN_OE_N)
      else $error("pin driven while input");
   chk_pin_driven: assert property (
      pin_out && $past(pin_out) |-> !SHARED_GENERAL_PIN_OE_N)
      else $error("pin not driven");
   chk_data_upper_zero: assert property (
      $past(RD) && $past(ADDR) == DATA_PORT_ADDR |-> RDATA[31:8] == 24'h0)
      else $error("data read upper bits set");
   chk_status_upper_zero: assert property (
      $past(RD) && $past(ADDR) == RX_STATUS_ADDR |-> RDATA[31:4] == 28'h0)
      else $error("status read upper bits set");
   chk_status_clear: assert property (
      WR && ADDR == RX_STATUS_ADDR ##1 RD && ADDR == RX_STATUS_ADDR
      |=> RDATA[3:0] == 4'h0)
      else $error("status not cleared");
   chk_tx_idle_high: assert property (
      RS485_DRIVE_ENABLE_OUT_N |-> SERIAL_TRANSMIT_PIN)
      else $error("line low outside frame");
   chk_dma_tx_take: assert property (
      DMA_TX_VALID && DMA_TX_READY |=> !DMA_TX_READY)
      else $error("dma ready stayed high");
endmodule
bind uart_path_top uart_path_checker i_uart_path_checker (.CLK, .RST,
   .ADDR, .WR, .RD, .RDATA, .PIN_CFG, .SERIAL_TRANSMIT_PIN,
   .SHARED_GENERAL_PIN_OE_N, .HDLC_CLOCK_TO_CORE,
   .RS485_DRIVE_ENABLE_OUT_N, .DMA_TX_VALID, .DMA_TX_READY);

//--- uart_line_partner.sv
`timescale 1ns/1ps
module uart_line_partner
#(
   parameter int BIT = 32
)
(
   input wire logic CLK, // Clock
   input wire logic txd, // Line from block
   output logic rxd, // Line to block
   output logic got, // Frame decoded
   output logic [9:0] word // Data, parity, stop
);
   initial
   begin
      rxd = 1'h1;
      got = 1'h0;
   end
   // Frame with chosen parity and stop values, then one idle bit
   task automatic send(input logic [7:0] d, input logic p, input logic s);
      logic [9:0] f;
      f = {s, p, d};
      rxd <= 1'h0;
      repeat (BIT) @(posedge CLK);
      for (int i = 0; i < 10; i++)
      begin
         rxd <= f[i];
         repeat (BIT) @(posedge CLK);
      end
      rxd <= 1'h1;
      repeat (BIT) @(posedge CLK);
      #1;
   endtask
   task automatic hold_low(input int n);
      rxd <= 1'h0;
      repeat (n * BIT) @(posedge CLK);
      rxd <= 1'h1;
      repeat (BIT) @(posedge CLK);
      #1;
   endtask
   // Samples each bit at its centre
   always
   begin
      @(negedge txd);
      repeat (BIT / 2) @(posedge CLK);
      for (int i = 0; i < 10; i++)
      begin
         repeat (BIT) @(posedge CLK);
         word[i] = txd;
      end
      got <= 1'h1;
      @(posedge CLK);
      got <= 1'h0;
   end
endmodule

//--- tb_uart_path_top.sv
`timescale 1ns/1ps
module tb_uart_path_top;
   import uart_path_pkg::*;
   logic CLK, RST, WR, RD, INT_HDLC_CLK, TX_DMA_EN, RX_DMA_EN;
   logic [31:0] ADDR, WDATA, RDATA;
   line_ctrl_t LINE_CTRL;
   pin_cfg_t PIN_CFG;
   logic DMA_TX_VALID, DMA_TX_READY, DMA_RX_VALID, DMA_RX_READY;
   logic [7:0] DMA_TX_DATA, DMA_RX_DATA, b, c;
   logic SERIAL_RECEIVE_PIN, SERIAL_TRANSMIT_PIN, SHARED_GENERAL_PIN_IN;
   logic SHARED_GENERAL_PIN_OUT, SHARED_GENERAL_PIN_OE_N;
   logic HDLC_CLOCK_TO_CORE, RS485_DRIVE_ENABLE_OUT_N;
   logic ext_lvl, got, rd_d, drv;
   logic [9:0] word;
   logic [31:0] rq[$];
   logic [9:0] tq[$];
   logic [7:0] dq[$];
   int failures, checks, seed;
   assign SHARED_GENERAL_PIN_IN = SHARED_GENERAL_PIN_OE_N ? ext_lvl
      : SHARED_GENERAL_PIN_OUT;
   uart_path_top #(.FIFO_DEPTH(4)) i_uart_path_top (.CLK, .RST, .ADDR,
      .WR, .RD, .WDATA, .RDATA, .LINE_CTRL, .PIN_CFG, .INT_HDLC_CLK,
      .TX_DMA_EN, .RX_DMA_EN, .DMA_TX_VALID, .DMA_TX_DATA, .DMA_TX_READY,
      .DMA_RX_VALID, .DMA_RX_DATA, .DMA_RX_READY, .SERIAL_RECEIVE_PIN,
      .SERIAL_TRANSMIT_PIN, .SHARED_GENERAL_PIN_IN, .SHARED_GENERAL_PIN_OUT,
      .SHARED_GENERAL_PIN_OE_N, .HDLC_CLOCK_TO_CORE,
      .RS485_DRIVE_ENABLE_OUT_N);
   uart_line_partner #(.BIT(32)) i_uart_line_partner (.CLK,
      .txd(SERIAL_TRANSMIT_PIN), .rxd(SERIAL_RECEIVE_PIN), .got, .word);
   initial
   begin
      CLK = 1'h0;
      forever #10 CLK = ~CLK;
   end
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e)
      begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic finish_test;
      $display("failures %0d checks %0d", failures, checks);
      if (failures == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Strobes stay up between back-to-back accesses
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      ADDR = a;
      WDATA = d;
      RD = 1'h0;
      WR = 1'h1;
      @(posedge CLK);
      #1;
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      rq.push_back(e);
      ADDR = a;
      WR = 1'h0;
      RD = 1'h1;
      @(posedge CLK);
      #1;
   endtask
   task automatic pause(input int n);
      WR = 1'h0;
      RD = 1'h0;
      repeat (n) @(posedge CLK);
      #1;
   endtask
   always @(posedge CLK)
   begin
      rd_d <= RD;
      if (rd_d)
         cmp(RDATA, rq.pop_front());
      if (got)
         cmp({22'h0, word}, {22'h0, tq.pop_front()});
      if (DMA_RX_VALID && DMA_RX_READY)
         cmp({24'h0, DMA_RX_DATA}, {24'h0, dq.pop_front()});
   end
   initial
   begin
      #1000000;
      failures++;
      finish_test();
   end
   initial
   begin
      seed = 53295;
      {RST, WR, RD, INT_HDLC_CLK, ext_lvl} = 5'h10;
      ADDR = 32'h0;
      WDATA = 32'h0;
      {TX_DMA_EN, RX_DMA_EN, DMA_TX_VALID, DMA_TX_DATA, DMA_RX_READY} = 12'h0;
      PIN_CFG = 4'h0;
      LINE_CTRL = {4'he, 2'h3, 16'h0001};
      repeat (20) @(posedge CLK);
      #1 RST = 1'h0;
      repeat (2)
      begin
         b = 8'($random(seed));
         tq.push_back({1'h1, ^b, b});
         wr(DATA_PORT_ADDR, {24'h0, b});
      end
      pause(1);
      b = 8'($random(seed));
      tq.push_back({1'h1, ^b, b});
      TX_DMA_EN = 1'h1;
      DMA_TX_DATA = b;
      DMA_TX_VALID = 1'h1;
      repeat (20)
      begin
         @(posedge CLK);
         if (DMA_TX_READY)
            break;
      end
      #1 DMA_TX_VALID = 1'h0;
      pause(1000);
      b = 8'($random(seed));
      c = 8'($random(seed)) | 8'h01;
      i_uart_line_partner.send(b, ^b, 1'h1);
      i_uart_line_partner.send(b, ~^b, 1'h1);
      i_uart_line_partner.send(c, ^c, 1'h0);
      rd(DATA_PORT_ADDR, {24'h0, b});
      rd(RX_STATUS_ADDR, 32'h0);
      rd(DATA_PORT_ADDR, {24'h0, b});
      rd(RX_STATUS_ADDR, 32'h2);
      rd(DATA_PORT_ADDR, {24'h0, c});
      rd(RX_STATUS_ADDR, 32'h1);
      pause(1);
      i_uart_line_partner.hold_low(30);
      i_uart_line_partner.send(c, ^c, 1'h1);
      rd(DATA_PORT_ADDR, 32'h0);
      rd(RX_STATUS_ADDR, 32'h5);
      wr(RX_STATUS_ADDR, $random(seed));
      rd(RX_STATUS_ADDR, 32'h0);
      rd(DATA_PORT_ADDR, {24'h0, c});
      pause(1);
      LINE_CTRL.fifo_mode_select = 1'h0;
      tq.push_back({1'h1, ^b, b});
      wr(DATA_PORT_ADDR, {24'h0, b});
      pause(1);
      i_uart_line_partner.send(b, ^b, 1'h1);
      i_uart_line_partner.send(c, ^c, 1'h1);
      rd(DATA_PORT_ADDR, {24'h0, b});
      rd(RX_STATUS_ADDR, 32'h8);
      rd(DATA_PORT_ADDR, 32'h0);
      wr(RX_STATUS_ADDR, 32'h0);
      rd(RX_STATUS_ADDR, 32'h0);
      pause(1);
      LINE_CTRL.fifo_mode_select = 1'h1;
      RX_DMA_EN = 1'h1;
      i_uart_line_partner.send(c, ^c, 1'h1);
      repeat (20)
      begin
         if (DMA_RX_VALID)
            break;
         @(posedge CLK);
         #1;
      end
      dq.push_back(c);
      DMA_RX_READY = 1'h1;
      pause(1);
      DMA_RX_READY = 1'h0;
      for (int i = 0; i < 16; i++)
      begin
         PIN_CFG = i[3:0];
         INT_HDLC_CLK = 1'($random(seed));
         ext_lvl = 1'($random(seed));
         pause(6);
         drv = i[1] ? i[2] & !i[0] : i[3] & !i[2] & !i[0];
         cmp(SHARED_GENERAL_PIN_OE_N, !drv);
         if (!i[1])
            cmp(HDLC_CLOCK_TO_CORE, 1'h0);
         else if (i[2:0] == 3'h2)
            cmp(HDLC_CLOCK_TO_CORE, ext_lvl);
         if (i[2:0] == 3'h6)
            cmp(SHARED_GENERAL_PIN_OUT, INT_HDLC_CLK);
         if (i == 8)
            cmp(SHARED_GENERAL_PIN_OUT, RS485_DRIVE_ENABLE_OUT_N);
      end
      // No parity, two stops, with the drive enable on the shared pin
      PIN_CFG = 4'h8;
      LINE_CTRL.parity_check_select = 1'h0;
      LINE_CTRL.two_stop = 1'h1;
      b = 8'($random(seed));
      tq.push_back({2'h3, b});
      wr(DATA_PORT_ADDR, {24'h0, b});
      pause(3);
      cmp(RS485_DRIVE_ENABLE_OUT_N, 1'h0);
      cmp(SHARED_GENERAL_PIN_OUT, 1'h0);
      pause(400);
      cmp(32'(tq.size()), 32'h0);
      cmp(32'(dq.size()), 32'h0);
      finish_test();
   end
endmodule
